// File: hw/qpc_pkg.sv
// ----------------------------------------------------------------
// Shared constants for the quadrature and pulse capture block
// ----------------------------------------------------------------
package qpc_pkg;

	// Bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register byte offsets
	localparam logic [7:0] OFS_ENC_CFG = 8'h00;
	localparam logic [7:0] OFS_LINES = 8'h04;
	localparam logic [7:0] OFS_POS = 8'h08;
	localparam logic [7:0] OFS_SPEED = 8'h0C;
	localparam logic [7:0] OFS_STS = 8'h10;
	localparam logic [7:0] OFS_MASK = 8'h14;
	localparam logic [7:0] OFS_PINS = 8'h18;
	localparam logic [7:0] OFS_PCH_BASE = 8'h20;
	localparam logic [7:0] PCH_STRIDE = 8'h08;
	localparam logic [7:0] OFS_PRES_REL = 8'h04;

	// Field positions
	localparam int CFG_EN_BIT = 0;
	localparam int CFG_PER_BIT = 1;
	localparam int STS_ERR_BIT = 0;
	localparam int STS_SPD_BIT = 1;
	localparam int STS_LOS_BASE = 2;
	localparam int PINS_LOS_BASE = 16;

	// Values after reset
	localparam logic [15:0] LINES_RST = 16'h00C8;
	localparam logic [31:0] MASK_RST = 32'h0000_0000;

	// Timing, figures in their own units
	localparam int CLK_HZ = 25_000_000;
	localparam int MAX_CPS = 1_000_000;
	localparam int MIN_STEP_CYC = CLK_HZ / MAX_CPS;
	localparam int SPD_WIN_MS = 15;
	localparam int SPD_WIN_CYC_DEF = CLK_HZ / 1000 * SPD_WIN_MS;
	localparam int LOS_MS = 100;
	localparam int LOS_CYC_DEF = CLK_HZ / 1000 * LOS_MS;

	// Speed scaling: rpm = cps * 60 / (lines * 4)
	localparam int RPM_SCALE = 60 * 1000 / (SPD_WIN_MS * 4);
	localparam int PER_RPM_NUM = CLK_HZ / 4 * 60;
	localparam int DUTY_SCALE = 1000;

	// Pulse counter width and divider latency
	localparam int CNT_W = 20;
	localparam int DIV_NW = 32;

	// Pulse input measurement modes, Gray ordered
	typedef enum logic [1:0] {
		PM_OFF = 2'b00,
		PM_WIDTH = 2'b01,
		PM_DUTY = 2'b11,
		PM_FREQ = 2'b10
	} qpc_pmode_e;

endpackage

// File: hw/qpc_top.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Each pulse input measures high width, duty cycle or frequency.
// - An enabled pulse input with no edges reports loss of signal.
// - Rotation direction comes from phase order of the two channels.
// - Both edges of both channels count, four counts per line.
// - Each counted step moves position up or down by direction.
// - Only the two quadrature channels are used; no index input.
// - Count rates up to one million per second are handled.
// - Speed in rpm equals counts per second times 60 over lines times 4.
// - Negative lines per turn reverses the counting direction.
// - Speed from time between steps or from steps in a fixed window.
// - Position is not retained; software loads the zero reference.
// - All inputs are sampled continuously whatever their use.
// - Each pulse input has its own enable and use setting; the two phase inputs share one encoder enable.
// - The position counter value is readable by software.

// ----------------------------------------------------------------
// Two-flop synchroniser
// ----------------------------------------------------------------
module qpc_sync #(parameter int W = 1) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	// First stage is read by the second stage only
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_ff <= '0;
			s2_ff <= '0;
		end else begin
			s1_ff <= d_i;
			s2_ff <= s1_ff;
		end
	end
	assign q_o = s2_ff;
endmodule

// ----------------------------------------------------------------
// Serial restoring divider, one quotient bit per clock
// ----------------------------------------------------------------
module qpc_div #(parameter int NW = 32, parameter int DW = 32) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic start_i,
	input wire logic [NW-1:0] num_i,
	input wire logic [DW-1:0] den_i,
	output logic busy_o,
	output logic done_o,
	output logic [NW-1:0] quot_o
);
	logic [DW-1:0] rem_ff;
	logic [DW-1:0] den_ff;
	logic [NW-1:0] q_ff;
	logic [6:0] cnt_ff;
	logic done_ff;
	logic [DW:0] trial;
	assign trial = {rem_ff, q_ff[NW-1]};
	// Start is ignored while busy; caller drops that sample
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rem_ff <= '0;
			den_ff <= '0;
			q_ff <= '0;
			cnt_ff <= '0;
			done_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			if (cnt_ff == 7'h00) begin
				if (start_i) begin
					rem_ff <= '0;
					q_ff <= num_i;
					den_ff <= den_i;
					cnt_ff <= 7'(NW);
				end
			end else begin
				if (trial >= {1'b0, den_ff}) begin
					rem_ff <= DW'(trial - {1'b0, den_ff});
					q_ff <= {q_ff[NW-2:0], 1'b1};
				end else begin
					rem_ff <= trial[DW-1:0];
					q_ff <= {q_ff[NW-2:0], 1'b0};
				end
				cnt_ff <= cnt_ff - 7'h01;
				done_ff <= (cnt_ff == 7'h01);
			end
		end
	end
	assign busy_o = (cnt_ff != 7'h00);
	assign done_o = done_ff;
	assign quot_o = q_ff;
endmodule

// ----------------------------------------------------------------
// Top: encoder counter, speed, pulse capture, APB slave
// ----------------------------------------------------------------
module qpc_top #(
	parameter int NP = 2,
	parameter int SPD_WIN_CYC = qpc_pkg::SPD_WIN_CYC_DEF,
	parameter int LOS_CYC = qpc_pkg::LOS_CYC_DEF
) (
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [qpc_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [qpc_pkg::DATA_W-1:0] pwdata_i,
	output logic [qpc_pkg::DATA_W-1:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic phase_lead_i,
	input wire logic phase_lag_i,
	input wire logic [NP-1:0] pulse_i,
	output logic irq_o
);
	import qpc_pkg::*;

	localparam logic [23:0] WIN_LAST = 24'(SPD_WIN_CYC - 1);
	localparam logic [23:0] LOS_LAST = 24'(LOS_CYC - 1);
	localparam int SW = NP + 2;

	logic [NP+1:0] pin_s;
	logic [NP+1:0] pin_d_ff;
	logic enc_en_ff, spd_per_ff;
	logic signed [15:0] lines_ff;
	logic [15:0] abs_lines;
	logic signed [31:0] pos_ff, speed_ff;
	logic [SW-1:0] sts_ff, sts_set, mask_ff;
	logic [31:0] prdata_ff, rd_data;
	logic hit, setup, wr_acc, pos_wr;
	logic ch_a, ch_b, fwd, step, both, cnt_up;
	logic [23:0] win_ff, gap_ff;
	logic signed [23:0] delta_ff, dstep;
	logic [23:0] abs_delta;
	logic win_end, gap_sat, lines_nz, sp_start, sp_busy, sp_done, sp_neg_ff;
	logic [31:0] sp_num, sp_q;
	logic [39:0] sp_den;
	qpc_pmode_e pmode_ff [NP];
	logic [31:0] pres [NP];
	logic [NP-1:0] los_v, los_rise;

	// ----------------------------------------------------------------
	// Input sampling
	// ----------------------------------------------------------------
	// All pins synchronised always, whatever their use; 25 samples per count at max rate
	qpc_sync #(.W(NP + 2)) u_sync (
		.clk_i(mclk_i),
		.rst_n_i(arst_n_i),
		.d_i({pulse_i, phase_lag_i, phase_lead_i}),
		.q_o(pin_s)
	);

	// Previous sample for edge detection
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_d_ff <= '0;
		end else begin
			pin_d_ff <= pin_s;
		end
	end

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	assign setup = psel_i & ~penable_i;
	assign wr_acc = psel_i & penable_i & pwrite_i;
	assign pos_wr = wr_acc & (paddr_i == OFS_POS);
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i & penable_i & ~hit;

	// Read decode; unmapped addresses read zero with an error
	always_comb begin
		rd_data = '0;
		hit = 1'b1;
		if (paddr_i == OFS_ENC_CFG) begin
			rd_data = {30'h0, spd_per_ff, enc_en_ff};
		end else if (paddr_i == OFS_LINES) begin
			rd_data = 32'(signed'(lines_ff));
		end else if (paddr_i == OFS_POS) begin
			rd_data = pos_ff;
		end else if (paddr_i == OFS_SPEED) begin
			rd_data = speed_ff;
		end else if (paddr_i == OFS_STS) begin
			rd_data = 32'(sts_ff);
		end else if (paddr_i == OFS_MASK) begin
			rd_data = 32'(mask_ff);
		end else if (paddr_i == OFS_PINS) begin
			rd_data = 32'(pin_s) | (32'(los_v) << PINS_LOS_BASE);
		end else begin
			hit = 1'b0;
			for (int i = 0; i < NP; i++) begin
				if (paddr_i == ADDR_W'(OFS_PCH_BASE + i * PCH_STRIDE)) begin
					hit = 1'b1;
					rd_data = {30'h0, pmode_ff[i]};
				end else if (paddr_i == ADDR_W'(OFS_PCH_BASE + i * PCH_STRIDE + OFS_PRES_REL)) begin
					hit = 1'b1;
					rd_data = pres[i];
				end
			end
		end
	end

	// Read data captured in setup so it comes from a flop in access
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prdata_ff <= '0;
		end else if (setup) begin
			prdata_ff <= rd_data;
		end
	end
	assign prdata_o = prdata_ff;

	// Encoder configuration and interrupt mask
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			enc_en_ff <= 1'b0;
			spd_per_ff <= 1'b0;
			lines_ff <= LINES_RST;
			mask_ff <= SW'(MASK_RST);
		end else if (wr_acc) begin
			if (paddr_i == OFS_ENC_CFG) begin
				enc_en_ff <= pwdata_i[CFG_EN_BIT];
				spd_per_ff <= pwdata_i[CFG_PER_BIT];
			end else if (paddr_i == OFS_LINES) begin
				lines_ff <= pwdata_i[15:0];
			end else if (paddr_i == OFS_MASK) begin
				mask_ff <= pwdata_i[SW-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Quadrature decode and position
	// ----------------------------------------------------------------
	// Only the two phase inputs exist; index outputs are never wired in
	assign ch_a = pin_s[0] ^ pin_d_ff[0];
	assign ch_b = pin_s[1] ^ pin_d_ff[1];
	assign fwd = ~(pin_d_ff[0] ^ pin_s[1]);
	assign step = enc_en_ff & (ch_a ^ ch_b);
	assign both = enc_en_ff & ch_a & ch_b;
	assign cnt_up = fwd ^ lines_ff[15];

	// A software load wins over a step in the same cycle
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pos_ff <= '0;
		end else if (pos_wr) begin
			pos_ff <= pwdata_i;
		end else if (step) begin
			pos_ff <= cnt_up ? pos_ff + 32'sh1 : pos_ff - 32'sh1;
		end
	end

	// ----------------------------------------------------------------
	// Speed measurement
	// ----------------------------------------------------------------
	assign abs_lines = lines_ff[15] ? 16'(-lines_ff) : lines_ff;
	assign lines_nz = (lines_ff != 16'sh0);
	assign win_end = (win_ff == WIN_LAST);
	assign gap_sat = (gap_ff == WIN_LAST);
	assign dstep = step ? (cnt_up ? 24'sh1 : -24'sh1) : 24'sh0;
	assign abs_delta = delta_ff[23] ? 24'(-delta_ff) : delta_ff;

	// Window counter, step count per window, cycles since last step
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			win_ff <= '0;
			delta_ff <= '0;
			gap_ff <= WIN_LAST;
		end else begin
			win_ff <= win_end ? 24'h0 : win_ff + 24'h1;
			delta_ff <= win_end ? dstep : delta_ff + dstep;
			if (step) begin
				gap_ff <= 24'h1;
			end else if (!gap_sat) begin
				gap_ff <= gap_ff + 24'h1;
			end
		end
	end

	// Window mode or period mode; a result still in the divider drops the next request
	assign sp_start = lines_nz & ~sp_busy &
		(spd_per_ff ? (step & ~gap_sat) : win_end);
	assign sp_num = spd_per_ff ? 32'(PER_RPM_NUM) : 32'(abs_delta) * 32'(RPM_SCALE);
	assign sp_den = spd_per_ff ? 40'(gap_ff) * 40'(abs_lines) : 40'(abs_lines);

	qpc_div #(.NW(DIV_NW), .DW(40)) u_spd_div (
		.clk_i(mclk_i),
		.rst_n_i(arst_n_i),
		.start_i(sp_start),
		.num_i(sp_num),
		.den_i(sp_den),
		.busy_o(sp_busy),
		.done_o(sp_done),
		.quot_o(sp_q)
	);

	// Signed speed; a stalled shaft in period mode reads zero
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sp_neg_ff <= 1'b0;
			speed_ff <= '0;
		end else begin
			if (sp_start) begin
				sp_neg_ff <= spd_per_ff ? ~cnt_up : delta_ff[23];
			end
			if (sp_done) begin
				speed_ff <= sp_neg_ff ? -signed'(sp_q) : signed'(sp_q);
			end else if (!lines_nz || (spd_per_ff && gap_sat)) begin
				speed_ff <= '0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Pulse capture channels
	// ----------------------------------------------------------------
	for (genvar i = 0; i < NP; i++) begin : g_pch
		logic [CNT_W-1:0] per_ff, hi_ff, hil_ff;
		logic [23:0] idle_ff;
		logic per_ok_ff, los_ff, en, rise, fall, edge_any, dv_done, idle_max;
		logic [31:0] res_ff, num, q;
		logic [CNT_W-1:0] den;
		assign rise = pin_s[2+i] & ~pin_d_ff[2+i];
		assign fall = ~pin_s[2+i] & pin_d_ff[2+i];
		assign edge_any = rise | fall;
		assign en = (pmode_ff[i] != PM_OFF);
		assign idle_max = en & (idle_ff == LOS_LAST);

		// Mode per input; any mode other than off enables the input
		always_ff @(posedge mclk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				pmode_ff[i] <= PM_OFF;
			end else if (wr_acc && paddr_i == ADDR_W'(OFS_PCH_BASE + i * PCH_STRIDE)) begin
				pmode_ff[i] <= qpc_pmode_e'(pwdata_i[1:0]);
			end
		end

		// Period and high-time counters saturate rather than wrap
		always_ff @(posedge mclk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				per_ff <= '0;
				hi_ff <= '0;
				hil_ff <= '0;
				per_ok_ff <= 1'b0;
			end else begin
				per_ff <= rise ? CNT_W'(1) : (&per_ff ? per_ff : per_ff + CNT_W'(1));
				if (rise) begin
					hi_ff <= CNT_W'(1);
				end else if (pin_s[2+i] && !(&hi_ff)) begin
					hi_ff <= hi_ff + CNT_W'(1);
				end
				if (fall) begin
					hil_ff <= hi_ff;
				end
				if (idle_max || !en) begin
					per_ok_ff <= 1'b0;
				end else if (rise) begin
					per_ok_ff <= 1'b1;
				end
			end
		end

		// Idle timer; a steady level is never taken as a measurement
		always_ff @(posedge mclk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				idle_ff <= '0;
				los_ff <= 1'b0;
			end else begin
				idle_ff <= edge_any ? 24'h0 : (idle_ff == LOS_LAST ? idle_ff : idle_ff + 24'h1);
				los_ff <= idle_max;
			end
		end
		assign los_v[i] = los_ff;
		assign los_rise[i] = idle_max & ~los_ff;

		// Width in cycles, duty per mille, or frequency in Hz
		always_comb begin
			num = 32'(CLK_HZ);
			den = per_ff;
			case (pmode_ff[i])
				PM_WIDTH: begin
					num = 32'(hil_ff);
					den = CNT_W'(1);
				end
				PM_DUTY: begin
					num = 32'(hil_ff) * 32'(DUTY_SCALE);
				end
				default: begin
				end
			endcase
		end

		qpc_div #(.NW(DIV_NW), .DW(CNT_W)) u_div (
			.clk_i(mclk_i),
			.rst_n_i(arst_n_i),
			.start_i(rise & per_ok_ff & en),
			.num_i(num),
			.den_i(den),
			.busy_o(),
			.done_o(dv_done),
			.quot_o(q)
		);

		// Result clears on loss of signal or disable
		always_ff @(posedge mclk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				res_ff <= '0;
			end else if (!en || los_ff) begin
				res_ff <= '0;
			end else if (dv_done) begin
				res_ff <= q;
			end
		end
		assign pres[i] = res_ff;
	end

	// ----------------------------------------------------------------
	// Status and interrupt
	// ----------------------------------------------------------------
	assign sts_set = {los_rise, sp_done, both};

	// A set in the same cycle as a write-one-to-clear wins
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sts_ff <= '0;
		end else if (wr_acc && paddr_i == OFS_STS) begin
			sts_ff <= (sts_ff & ~pwdata_i[SW-1:0]) | sts_set;
		end else begin
			sts_ff <= sts_ff | sts_set;
		end
	end
	assign irq_o = |(sts_ff & mask_ff);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i);

	AST_SYNC_DLY: assert property ($past(arst_n_i, 3) |->
		pin_s == $past({pulse_i, phase_lag_i, phase_lead_i}, 2)) else $error("sync delay not two");
	AST_CNT_UP: assert property (step && cnt_up && !pos_wr |=>
		pos_ff == $past(pos_ff) + 32'sh1) else $error("position did not increment");
	AST_CNT_DN: assert property (step && !cnt_up && !pos_wr |=>
		pos_ff == $past(pos_ff) - 32'sh1) else $error("position did not decrement");
	AST_DIR: assert property (enc_en_ff && ch_a && !ch_b && pin_s[0] != pin_s[1]
		&& !lines_ff[15] && !pos_wr |=> pos_ff == $past(pos_ff) + 32'sh1) else $error("lead phase not forward");
	AST_REV: assert property (step && fwd && lines_ff[15] && !pos_wr |=>
		pos_ff == $past(pos_ff) - 32'sh1) else $error("negative lines not reversed");
	AST_BOTH: assert property (both && !pos_wr |=>
		$stable(pos_ff) && sts_ff[STS_ERR_BIT]) else $error("double change not dropped");
	AST_OFF: assert property (!enc_en_ff && !pos_wr |=> $stable(pos_ff)) else $error("disabled encoder counted");
	AST_SPD_LAT: assert property (sp_start |-> ##33 sp_done) else $error("speed result late");
	AST_LOS: assert property (g_pch[0].idle_max && !los_v[0] |=>
		los_v[0] && sts_ff[STS_LOS_BASE] ##1 pres[0] == 32'h0) else $error("loss of signal missed");
	AST_LOAD: assert property (pos_wr |=> pos_ff == $past(pwdata_i)) else $error("position load lost");

	COV_STEP: cover property (step && cnt_up);
	COV_BACK: cover property (step && !cnt_up);
	COV_SPD: cover property (sp_done && speed_ff != 32'sh0);
	COV_LOS: cover property (los_rise[0]);
endmodule
`default_nettype wire

// File: tb/qpc_enc_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Encoder and pulse sensor model
// ----------------------------------------------------------------
module qpc_enc_model #(parameter int NP = 2) (
	input wire logic clk_i,
	input wire logic step_i,
	input wire logic dir_i,
	input wire logic both_i,
	input wire logic [NP-1:0] pen_i,
	input wire logic [15:0] hi_i,
	input wire logic [15:0] per_i,
	output logic phase_lead_o,
	output logic phase_lag_o,
	output logic [NP-1:0] pulse_o
);
	import qpc_pkg::*;
	logic a_q = 1'b0;
	logic b_q = 1'b0;
	int gap_q = 100;
	logic pls_q [NP] = '{default: 1'b0};
	logic [15:0] cnt_q [NP] = '{default: 16'h0000};

	// Gray walk 00,10,11,01 forward; no index line exists at all
	always @(posedge clk_i) begin
		gap_q <= gap_q + 1;
		// Too-early requests held off, real encoders never exceed the rate
		if (step_i && gap_q >= MIN_STEP_CYC) begin
			gap_q <= 1; // Cycles since this step, so a spacing of exactly the minimum passes
			if (both_i) begin
				a_q <= ~a_q;
				b_q <= ~b_q;
			end else if ((a_q == b_q) == dir_i) begin
				a_q <= ~a_q;
			end else begin
				b_q <= ~b_q;
			end
		end
	end
	assign phase_lead_o = a_q;
	assign phase_lag_o = b_q;

	// Pulse trains; a silent sensor holds its line low
	for (genvar i = 0; i < NP; i++) begin : g_pls
		always @(posedge clk_i) begin
			pls_q[i] <= pen_i[i] && (cnt_q[i] < hi_i);
			cnt_q[i] <= (!pen_i[i] || cnt_q[i] == per_i - 16'h0001) ? 16'h0000 : cnt_q[i] + 16'h0001;
		end
		assign pulse_o[i] = pls_q[i];
	end
endmodule
`default_nettype wire

// File: tb/qpc_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module qpc_tb_top;
	import qpc_pkg::*;
	localparam int NP = 2;
	localparam int WIN = 400;
	localparam int LOS = 200;
	localparam logic [7:0] P0R = OFS_PCH_BASE + OFS_PRES_REL;
	localparam logic [7:0] P1C = OFS_PCH_BASE + PCH_STRIDE;
	localparam logic [7:0] P1R = P1C + OFS_PRES_REL;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, lead, lag, irq;
	logic [NP-1:0] pulse, pen = '0;
	logic step = 1'b0, dir = 1'b0, both = 1'b0;
	logic [15:0] hi = 16'h0000, per = 16'h0001;
	int n_fail = 0;
	int checks_done = 0;

	qpc_top #(.NP(NP), .SPD_WIN_CYC(WIN), .LOS_CYC(LOS)) dut_u (.mclk_i(mclk), .arst_n_i(arst_n),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .phase_lead_i(lead),
		.phase_lag_i(lag), .pulse_i(pulse), .irq_o(irq));
	qpc_enc_model #(.NP(NP)) partner_u (.clk_i(mclk), .step_i(step), .dir_i(dir), .both_i(both),
		.pen_i(pen), .hi_i(hi), .per_i(per), .phase_lead_o(lead), .phase_lag_o(lag), .pulse_o(pulse));

	// ----------------------------------------------------------------
	// Shared helpers
	// ----------------------------------------------------------------
	task automatic end_sim;
		if (n_fail == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Held until pready is seen high, never a fixed count
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1)
			@(posedge mclk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		check(nm, q & m, exp);
	endtask
	// Irq is combinational from registers, so look mid-cycle
	task automatic chk_irq(input string nm, input logic exp);
		@(negedge mclk);
		check(nm, {31'h0, irq}, {31'h0, exp});
	endtask
	task automatic steps(input int n, input logic d, input logic b, input int gap);
		repeat (n) begin
			@(posedge mclk);
			step <= 1'b1;
			dir <= d;
			both <= b;
			@(posedge mclk);
			step <= 1'b0;
			repeat (gap - 2) @(posedge mclk);
		end
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		logic [31:0] q;
		logic e;
		rd("lines", OFS_LINES, '1, {16'h0, LINES_RST});
		rd("mask", OFS_MASK, '1, MASK_RST);
		rd("pos", OFS_POS, '1, 32'h0);
		apb(1'b0, 8'h1C, 32'h0, q, e);
		check("unmapped err", {31'h0, e}, 32'h1);
		check("unmapped data", q, 32'h0);
		// Encoder still disabled: pins seen, nothing counted
		steps(1, 1'b1, 1'b0, 30);
		rd("pins", OFS_PINS, 32'h3, 32'h1);
		rd("pos off", OFS_POS, '1, 32'h0);
	endtask
	task automatic t_count;
		wr(OFS_ENC_CFG, 32'h1);
		wr(OFS_POS, 32'h0);
		steps(7, 1'b1, 1'b0, 30);
		rd("pos fwd", OFS_POS, '1, 32'd7);
		steps(3, 1'b0, 1'b0, 25);
		rd("pos rev", OFS_POS, '1, 32'd4);
		wr(OFS_LINES, 32'hFFFF_FF38);
		rd("lines neg", OFS_LINES, '1, 32'hFFFF_FF38);
		wr(OFS_POS, 32'h0);
		steps(4, 1'b1, 1'b0, 30);
		rd("pos neg", OFS_POS, '1, 32'hFFFF_FFFC);
		wr(OFS_LINES, 32'd200);
	endtask
	task automatic t_glitch;
		wr(OFS_STS, '1);
		wr(OFS_MASK, 32'h1);
		chk_irq("irq idle", 1'b0);
		steps(1, 1'b1, 1'b1, 30);
		rd("pos glitch", OFS_POS, '1, 32'hFFFF_FFFC);
		rd("sts glitch", OFS_STS, 32'h1, 32'h1);
		chk_irq("irq set", 1'b1);
		wr(OFS_MASK, 32'h0);
		chk_irq("irq masked", 1'b0);
		wr(OFS_MASK, 32'h1);
		chk_irq("irq unmasked", 1'b1);
		wr(OFS_STS, 32'h1);
		chk_irq("irq cleared", 1'b0);
		rd("sts cleared", OFS_STS, 32'h1, 32'h0);
	endtask
	task automatic t_speed;
		int rpm;
		rpm = PER_RPM_NUM / (100 * 200);
		wr(OFS_ENC_CFG, 32'h3);
		wr(OFS_STS, '1);
		steps(6, 1'b1, 1'b0, 100);
		rd("rpm fwd", OFS_SPEED, '1, 32'(rpm));
		rd("spd ready", OFS_STS, 32'h2, 32'h2);
		steps(6, 1'b0, 1'b0, 100);
		rd("rpm rev", OFS_SPEED, '1, 32'(-rpm));
		repeat (WIN + 50) @(posedge mclk);
		rd("rpm stop", OFS_SPEED, '1, 32'h0);
		// Window mode: ten steps land in every full window
		wr(OFS_ENC_CFG, 32'h1);
		wr(OFS_LINES, 32'd1000);
		steps(25, 1'b1, 1'b0, 40);
		rd("rpm win", OFS_SPEED, '1, 32'((WIN / 40) * RPM_SCALE / 1000));
		wr(OFS_LINES, 32'd200);
	endtask
	task automatic t_pulse;
		hi <= 16'd30;
		per <= 16'd100;
		wr(OFS_PCH_BASE, {30'h0, PM_WIDTH});
		wr(P1C, {30'h0, PM_DUTY});
		pen <= 2'b11;
		repeat (400) @(posedge mclk);
		rd("width", P0R, '1, 32'd30);
		rd("duty", P1R, '1, 32'(DUTY_SCALE * 30 / 100));
		wr(OFS_PCH_BASE, {30'h0, PM_FREQ});
		wr(P1C, {30'h0, PM_OFF});
		repeat (300) @(posedge mclk);
		rd("freq", P0R, '1, 32'(CLK_HZ / 100));
		rd("off", P1R, '1, 32'h0);
		// Sensor goes quiet: only the active channel may flag
		wr(OFS_STS, '1);
		wr(OFS_MASK, 32'h4);
		pen <= 2'b00;
		repeat (LOS + 60) @(posedge mclk);
		rd("los sts", OFS_STS, 32'hC, 32'h4);
		rd("los pins", OFS_PINS, 32'h3_0000, 32'h1_0000);
		rd("los res", P0R, '1, 32'h0);
		chk_irq("los irq", 1'b1);
	endtask

	// ----------------------------------------------------------------
	// Clock, reset, sequence, watchdog
	// ----------------------------------------------------------------
	initial begin
		forever #20 mclk = ~mclk;
	end
	initial begin
		repeat (4) @(posedge mclk);
		arst_n <= 1'b1;
		t_reset();
		t_count();
		t_glitch();
		t_speed();
		t_pulse();
		end_sim();
	end
	// Whole sequence is near 4200 cycles; a hang stops well after
	initial begin
		repeat (60000) @(posedge mclk);
		n_fail++;
		end_sim();
	end
endmodule
`default_nettype wire
